/* verilog/asrc_host.sv */
// Host controller that drives a 512k by 8 asynchronous static memory
// Contract
// - Cycle no shorter than access time
// - Select low long enough before end
// - Address stable long enough before end
// - Address valid by write start
// - Write data valid before write end
// - Pulse covers overlap plus float delay
// - Never drive against driving memory
// - Select high before supply drops
`timescale 1ns/1ps
`default_nettype none
module asrc_host
  import asrc_pkg::*;
(
  input wire logic clk,
  input wire logic srst,
  input wire logic req_valid,
  output logic req_ready,
  input wire logic req_write,
  input wire logic [asrc_pkg::ASRC_ADDR_W-1:0] req_addr,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] req_wdata,
  input wire logic retain_req,
  output logic retain_ok,
  output logic rsp_valid,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] rsp_rdata,
  output logic [asrc_pkg::ASRC_ADDR_W-1:0] mem_addr,
  output logic mem_sel_n,
  output logic mem_oe_n,
  output logic mem_we_n,
  input wire logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_i,
  output logic [asrc_pkg::ASRC_DATA_W-1:0] mem_data_o,
  output logic mem_data_oe
);
  import asrc_pkg::*;

  asrc_state_t state;
  asrc_state_t next_state;
  logic [2:0] cnt;
  logic [2:0] next_cnt;
  logic [ASRC_DATA_W-1:0] sync1;
  logic [ASRC_DATA_W-1:0] sync2;
  logic [ASRC_DATA_W-1:0] sync3;
  wire cnt_done;
  wire start;

  assign cnt_done = (cnt == ASRC_CNT_W0);
  assign req_ready = (state == ASRC_IDLE) && !retain_req;
  assign start = req_valid && req_ready;

  // Read data passes three flops; the first feeds only the second
  always_ff @(posedge clk)
  begin
    sync1 <= mem_data_i;
    sync2 <= sync1;
    sync3 <= sync2;
  end

  always_comb
  begin
    next_state = state;
    next_cnt = cnt_done ? cnt : cnt - 3'h1;
    case (state)
      ASRC_IDLE:
      begin
        if (start && req_write)
        begin
          next_state = ASRC_WSET;
          next_cnt = ASRC_CNT_W0;
        end
        else if (start)
        begin
          // Wait access plus three sync stages before taking data
          next_state = ASRC_READ;
          next_cnt = 3'(ASRC_READ_CYC + 2);
        end
      end
      ASRC_READ:
        if (cnt_done)
          next_state = ASRC_IDLE;
      ASRC_WSET:
      begin
        // Address, data and select settle before the strobe falls
        next_state = ASRC_WPULSE;
        next_cnt = 3'(ASRC_WRITE_CYC - 1);
      end
      ASRC_WPULSE:
        if (cnt_done)
          next_state = ASRC_WEND;
      ASRC_WEND:
      begin
        next_state = ASRC_RECOVER;
        next_cnt = 3'(ASRC_FLOAT_CYC - 1);
      end
      ASRC_RECOVER:
        if (cnt_done)
          next_state = ASRC_IDLE;
      default:
        next_state = ASRC_IDLE;
    endcase
  end

  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      state <= ASRC_IDLE;
      cnt <= ASRC_CNT_W0;
    end
    else
    begin
      state <= next_state;
      cnt <= next_cnt;
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge clk)
  begin
    if (srst)
    begin
      mem_addr <= '0;
      mem_sel_n <= 1'b1;
      mem_oe_n <= 1'b1;
      mem_we_n <= 1'b1;
      mem_data_o <= '0;
      mem_data_oe <= 1'b0;
      rsp_valid <= 1'b0;
      rsp_rdata <= '0;
    end
    else
    begin
      rsp_valid <= 1'b0;
      if (start)
      begin
        mem_addr <= req_addr;
        mem_sel_n <= 1'b0;
        // Reads use output enable; writes keep it high
        mem_oe_n <= req_write;
        if (req_write)
          mem_data_o <= req_wdata;
        mem_data_oe <= req_write;
      end
      if (state == ASRC_WSET)
        mem_we_n <= 1'b0;
      if (state == ASRC_WPULSE && cnt_done)
        mem_we_n <= 1'b1;
      if (state == ASRC_WEND)
      begin
        // Data held one edge after strobe rises, then deselect
        mem_sel_n <= 1'b1;
        mem_data_oe <= 1'b0;
      end
      if (state == ASRC_READ && cnt_done)
      begin
        rsp_valid <= 1'b1;
        rsp_rdata <= sync3;
        mem_sel_n <= 1'b1;
        mem_oe_n <= 1'b1;
      end
    end
  end

  // Retention only granted while deselected and idle
  assign retain_ok = retain_req && (state == ASRC_IDLE) && mem_sel_n;

  a_bus_no_fight: assert property (@(posedge clk) disable iff (srst)
    mem_data_oe |-> mem_oe_n) else $error("host drives bus while memory enabled");
  a_strobe_sel: assert property (@(posedge clk) disable iff (srst)
    !mem_we_n |-> !mem_sel_n && mem_data_oe) else $error("strobe low without select or data");
  sequence s_pulse;
    $fell(mem_we_n) ##0 (!mem_we_n) [*2];
  endsequence
  a_pulse_len: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_we_n) |-> s_pulse) else $error("write pulse too short");
  a_addr_stable: assert property (@(posedge clk) disable iff (srst)
    !mem_we_n |-> $stable(mem_addr)) else $error("address moved during write");
  a_data_stable: assert property (@(posedge clk) disable iff (srst)
    $rose(mem_we_n) |-> mem_data_oe && $stable(mem_data_o)) else $error("data changed at write end");
  a_read_time: assert property (@(posedge clk) disable iff (srst)
    (start && !req_write) |=> (state == ASRC_READ) [*5] ##1 rsp_valid) else $error("read timing wrong");
  a_retain_desel: assert property (@(posedge clk) disable iff (srst)
    retain_ok |-> mem_sel_n && mem_we_n) else $error("retention while selected");
  a_sel_before: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_we_n) |-> !$past(mem_sel_n)) else $error("select not ahead of strobe");

  // Every selected cycle lasts at least the slow grade cycle time
  sequence s_sel_hold;
    (!mem_sel_n) [*2];
  endsequence
  a_sel_cycle: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_sel_n) |-> s_sel_hold) else $error("select cycle too short");
  a_rsp_pulse: assert property (@(posedge clk) disable iff (srst)
    rsp_valid |=> !rsp_valid) else $error("read answer longer than one cycle");

  // Write strobe framing: select, address and data settled around the pulse
  a_sel_at_end: assert property (@(posedge clk) disable iff (srst)
    $rose(mem_we_n) |-> !mem_sel_n) else $error("select released before write end");
  a_addr_at_start: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_we_n) |-> $stable(mem_addr)) else $error("address not set at write start");
  a_data_before: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_we_n) |-> $past(mem_data_oe) && $stable(mem_data_o)) else $error("write data late");

  // Bus ownership and retention: output enable and host drive never overlap, no request taken during retention
  a_oe_in_write: assert property (@(posedge clk) disable iff (srst)
    !mem_we_n |-> mem_oe_n) else $error("output enable low during write");
  a_release_first: assert property (@(posedge clk) disable iff (srst)
    $fell(mem_oe_n) |-> !$past(mem_data_oe)) else $error("host still driving at read start");
  a_retain_block: assert property (@(posedge clk) disable iff (srst)
    retain_req |-> !req_ready) else $error("request accepted during retention");
endmodule // asrc_host
`default_nettype wire

/* verilog/asrc_pkg.sv */
// Package for the asynchronous static memory host controller
package asrc_pkg;
  localparam int ASRC_CLK_NS = 40;
  localparam int ASRC_ADDR_W = 19;
  localparam int ASRC_DATA_W = 8;
  // Slow grade figures in ns
  localparam int ASRC_READ_CYCLE_NS = 70;
  localparam int ASRC_ACCESS_NS = 70;
  localparam int ASRC_OE_ACCESS_NS = 35;
  localparam int ASRC_WRITE_PULSE_NS = 60;
  localparam int ASRC_DATA_OVERLAP_NS = 30;
  localparam int ASRC_WRITE_FLOAT_NS = 25;
  localparam int ASRC_HOLD_NS = 10;
  // Least times round up to whole cycles
  localparam int ASRC_READ_CYC = (ASRC_ACCESS_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
  localparam int ASRC_WP_MIN_NS = (ASRC_DATA_OVERLAP_NS + ASRC_WRITE_FLOAT_NS > ASRC_WRITE_PULSE_NS)
    ? ASRC_DATA_OVERLAP_NS + ASRC_WRITE_FLOAT_NS : ASRC_WRITE_PULSE_NS;
  localparam int ASRC_WRITE_CYC = (ASRC_WP_MIN_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
  localparam int ASRC_FLOAT_CYC = (ASRC_WRITE_FLOAT_NS + ASRC_CLK_NS - 1) / ASRC_CLK_NS;
  localparam logic [2:0] ASRC_CNT_W0 = 3'h0;
  typedef enum logic [2:0]
  {
    ASRC_IDLE = 3'b000,
    ASRC_READ = 3'b001,
    ASRC_WSET = 3'b010,
    ASRC_WPULSE = 3'b011,
    ASRC_WEND = 3'b100,
    ASRC_RECOVER = 3'b101
  } asrc_state_t;
endpackage

/* tb/asrc_sram_model.sv */
// Behavioural model of the 512k by 8 asynchronous memory
`timescale 1ns/1ps
`default_nettype none
module asrc_sram_model
(
  input wire logic [18:0] addr,
  input wire logic sel_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic [7:0] din,
  output logic [7:0] q,
  output logic q_en
);
  logic [7:0] mem [0:19'h7FFFF];
  logic [7:0] rd;
  always @(posedge we_n) if (!sel_n) mem[addr] = din;
  always @(posedge sel_n) if (!we_n) mem[addr] = din;
  always @(addr, sel_n, we_n) rd = mem[addr];
  // Slow grade access delay
  assign #70 q = rd;
  assign q_en = !sel_n && we_n && !oe_n;
endmodule // asrc_sram_model
`default_nettype wire

/* tb/tb_async_sram_512k_by_8.sv */
// Testbench of the static memory host controller
`timescale 1ns/1ps
`default_nettype none
module tb_async_sram_512k_by_8;
  import asrc_pkg::*;
  logic clk = 0, srst = 1, req_valid = 0, req_write = 0, retain_req = 0;
  logic [18:0] req_addr = '0;
  logic [7:0] req_wdata = '0, bus, last = 8'h00;
  wire logic req_ready, retain_ok, rsp_valid, sel_n, oe_n, we_n, d_oe, q_en;
  wire logic [7:0] rsp_rdata, d_o, q;
  wire logic [18:0] addr;
  int n_errors = 0, n_checks = 0, cyc = 0;
  asrc_host dut (.clk(clk), .srst(srst), .req_valid(req_valid), .req_ready(req_ready), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .retain_req(retain_req), .retain_ok(retain_ok),
    .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .mem_addr(addr), .mem_sel_n(sel_n), .mem_oe_n(oe_n),
    .mem_we_n(we_n), .mem_data_i(bus), .mem_data_o(d_o), .mem_data_oe(d_oe));
  asrc_sram_model mem (.addr(addr), .sel_n(sel_n), .oe_n(oe_n), .we_n(we_n), .din(bus), .q(q), .q_en(q_en));
  always #20 clk = ~clk;
  // Undriven bus flips every cycle
  always @* bus = q_en ? q : (d_oe ? d_o : ~last);
  always @(posedge clk) last <= bus;
  always @(negedge clk) if (!srst) chk(!(q_en && d_oe), "bus contention");
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      n_errors++;
      conclude();
    end
  end
  task automatic chk(input logic ok, input string msg);
    n_checks++;
    if (ok !== 1'b1)
    begin
      n_errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask
  task automatic go(input logic w, input logic [18:0] a, input logic [7:0] d, output int n);
    n = 0;
    while (req_ready !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = d;
    @(negedge clk);
    req_valid = 0;
    n = 0;
    while ((w ? req_ready : rsp_valid) !== 1'b1 && n < 20)
    begin
      @(negedge clk);
      n++;
    end
  endtask
  task automatic wr(input logic [18:0] a, input logic [7:0] d);
    int n;
    go(1'b1, a, d, n);
    chk(n == 5, "write busy time");
  endtask
  task automatic rd(input logic [18:0] a, input logic [7:0] e);
    int n;
    go(1'b0, a, 8'h00, n);
    chk(n == ASRC_READ_CYC + 3 && rsp_rdata === e, "read data");
  endtask
  task automatic t_data();
    wr(19'h00000, 8'h3C);
    wr(19'h7FFFF, 8'hC3);
    wr(19'h7FFFF, 8'h5A);
    rd(19'h00000, 8'h3C);
    rd(19'h7FFFF, 8'h5A);
    wr(19'h12345, 8'hFF);
    rd(19'h12345, 8'hFF);
    $display("test data done");
  endtask
  task automatic t_retain();
    @(negedge clk);
    retain_req = 1;
    @(negedge clk);
    chk(retain_ok === 1'b1 && req_ready === 1'b0 && sel_n === 1'b1, "retain state");
    req_valid = 1;
    req_write = 1;
    req_addr = 19'h00000;
    req_wdata = 8'h99;
    repeat (5) @(negedge clk);
    chk(sel_n === 1'b1 && we_n === 1'b1, "request taken in retention");
    req_valid = 0;
    retain_req = 0;
    @(negedge clk);
    rd(19'h00000, 8'h3C);
    $display("test retain done");
  endtask
  task automatic conclude();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(negedge clk);
    srst = 0;
    chk(sel_n === 1'b1 && oe_n === 1'b1 && we_n === 1'b1 && d_oe === 1'b0, "reset pins");
    $display("test reset done");
    t_data();
    t_retain();
    conclude();
  end
endmodule // tb_async_sram_512k_by_8
`default_nettype wire
